// *** rtl/uart_pkg.sv ***
// shared constants and types for the dual serial port
package uart_pkg;
    localparam longint CLK_HZ = 50_000_000;
    localparam longint BAUD_MAX_BPS = 3_000_000;
    localparam longint OVS = 16;
    localparam int NCO_W = 16;
    localparam logic [15:0] BAUD_INC_MAX = 16'(BAUD_MAX_BPS * OVS * (64'd1 << NCO_W) / CLK_HZ);
    localparam logic [15:0] BAUD_RST = 16'h0970;
    localparam int FIFO_DEPTH = 16;
    localparam int PORT_SEL_BIT = 5;
    localparam logic [4:0] OFF_DATA = 5'h00;
    localparam logic [4:0] OFF_STAT = 5'h04;
    localparam logic [4:0] OFF_BAUD = 5'h08;
    localparam logic [4:0] OFF_CTRL = 5'h0C;
    localparam logic [4:0] OFF_ISR = 5'h10;
    localparam logic [4:0] OFF_IMR = 5'h14;
    localparam logic [15:0] CTRL_RST = 16'h020F;
    localparam int INT_W = 7;
    localparam int INT_RXLVL = 0;
    localparam int INT_TXLVL = 1;
    localparam int INT_TXDONE = 2;
    localparam int INT_OVR = 3;
    localparam int INT_PERR = 4;
    localparam int INT_FERR = 5;
    localparam int INT_BRK = 6;
    localparam int ST_TXE = 0;
    localparam int ST_TXF = 1;
    localparam int ST_RXE = 2;
    localparam int ST_RXF = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_CTS = 5;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_STICK = 2'h3;

    typedef struct packed {
        logic dma_rx_en;
        logic dma_tx_en;
        logic [2:0] level;
        logic flow;
        logic fifo_en;
        logic brk;
        logic stop2;
        logic stick;
        logic [1:0] parity;
        logic [1:0] wlen;
        logic rx_en;
        logic tx_en;
    } ctrl_t;

    typedef struct packed {
        logic brk;
        logic perr;
        logic ferr;
        logic [7:0] data;
    } rx_entry_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_START = 5'h02,
        S_DATA = 5'h04,
        S_PAR = 5'h08,
        S_STOP = 5'h10
    } ser_state_t;
endpackage

// *** rtl/dual_uart.sv ***
// two independent serial ports with fifos, apb registers, irq and dma requests
`timescale 1ns/100ps
`default_nettype none

module uart_fifo #(parameter int W = 8) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic one_deep,
    input wire logic push,
    input wire logic pop,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata,
    output logic [4:0] count,
    output logic full
);
    logic [W-1:0] mem [uart_pkg::FIFO_DEPTH];
    logic [3:0] wp_reg;
    logic [3:0] rp_reg;
    logic [4:0] cnt_reg;
    logic do_push;
    logic do_pop;

    assign full = one_deep ? (cnt_reg != 5'h00) : (cnt_reg == 5'(uart_pkg::FIFO_DEPTH));
    assign do_push = push && !full;
    assign do_pop = pop && (cnt_reg != 5'h00);
    assign rdata = mem[rp_reg];
    assign count = cnt_reg;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wp_reg] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= 4'h0;
            rp_reg <= 4'h0;
            cnt_reg <= 5'h00;
        end else begin
            wp_reg <= wp_reg + 4'(do_push);
            rp_reg <= rp_reg + 4'(do_pop);
            cnt_reg <= cnt_reg + 5'(do_push) - 5'(do_pop);
        end
    end
endmodule

module uart_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic rd,
    input wire logic [4:0] addr,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata,
    output logic hit,
    input wire logic rx,
    input wire logic cts_n,
    output logic tx,
    output logic rts_n,
    output logic irq,
    output logic tx_dma_single,
    output logic tx_dma_burst,
    output logic rx_dma_single,
    output logic rx_dma_burst
);
    uart_pkg::ctrl_t ctrl_reg;
    logic [15:0] inc_reg;
    logic [15:0] acc_reg;
    logic tick_reg;
    logic [uart_pkg::INT_W-1:0] isr_reg;
    logic [uart_pkg::INT_W-1:0] imr_reg;
    logic [uart_pkg::INT_W-1:0] ev;
    logic [4:0] thr;
    logic [2:0] nbits;
    logic [7:0] dmask;
    logic [7:0] tx_head;
    logic [4:0] tx_cnt;
    logic tx_full;
    logic tx_push;
    logic tx_pop;
    uart_pkg::rx_entry_t rx_head;
    uart_pkg::rx_entry_t rx_in;
    logic [4:0] rx_cnt;
    logic rx_full;
    logic rx_push;
    logic rx_pop;
    logic rx_lvl;
    logic tx_lvl;
    logic rx_lvl_reg;
    logic tx_lvl_reg;
    uart_pkg::ser_state_t ts_reg;
    logic [3:0] ttick_reg;
    logic [2:0] tbit_reg;
    logic [7:0] tsh_reg;
    logic tx_next;
    logic tx_done;
    uart_pkg::ser_state_t rs_reg;
    logic [3:0] rtick_reg;
    logic [2:0] rbit_reg;
    logic [7:0] rsh_reg;
    logic rpar_reg;
    logic rx_m_reg;
    logic rx_s_reg;
    logic rx_d_reg;
    logic exp_par;
    logic tx_par;

    assign nbits = {1'b0, ctrl_reg.wlen} + 3'h4;
    assign dmask = 8'hFF >> (2'h3 - ctrl_reg.wlen);

    always_comb begin
        if (!ctrl_reg.fifo_en) begin
            thr = 5'h01;
        end else begin
            unique case (ctrl_reg.level)
                3'h0: thr = 5'h02;
                3'h1: thr = 5'h04;
                3'h2: thr = 5'h08;
                3'h3: thr = 5'h0C;
                default: thr = 5'h0E;
            endcase
        end
    end

    // baud tick: fractional accumulator on the system clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            {tick_reg, acc_reg} <= {1'b0, acc_reg} + {1'b0, inc_reg};
        end
    end

    assign hit = (addr == uart_pkg::OFF_DATA) || (addr == uart_pkg::OFF_STAT) ||
                 (addr == uart_pkg::OFF_BAUD) || (addr == uart_pkg::OFF_CTRL) ||
                 (addr == uart_pkg::OFF_ISR) || (addr == uart_pkg::OFF_IMR);
    assign tx_push = wr && (addr == uart_pkg::OFF_DATA);
    assign rx_pop = rd && (addr == uart_pkg::OFF_DATA);

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (addr)
            uart_pkg::OFF_DATA: rdata = {21'h000000, rx_head};
            uart_pkg::OFF_STAT: begin
                rdata[uart_pkg::ST_TXE] = (tx_cnt == 5'h00);
                rdata[uart_pkg::ST_TXF] = tx_full;
                rdata[uart_pkg::ST_RXE] = (rx_cnt == 5'h00);
                rdata[uart_pkg::ST_RXF] = rx_full;
                rdata[uart_pkg::ST_BUSY] = (ts_reg != uart_pkg::S_IDLE);
                rdata[uart_pkg::ST_CTS] = !cts_n;
            end
            uart_pkg::OFF_BAUD: rdata = {16'h0000, inc_reg};
            uart_pkg::OFF_CTRL: rdata = {16'h0000, ctrl_reg};
            uart_pkg::OFF_ISR: rdata = {25'h0000000, isr_reg};
            uart_pkg::OFF_IMR: rdata = {25'h0000000, imr_reg};
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= uart_pkg::ctrl_t'(uart_pkg::CTRL_RST);
            inc_reg <= uart_pkg::BAUD_RST;
            imr_reg <= '0;
        end else if (wr) begin
            if (addr == uart_pkg::OFF_CTRL) begin
                ctrl_reg <= uart_pkg::ctrl_t'(wdata[15:0]);
            end
            if (addr == uart_pkg::OFF_BAUD) begin
                inc_reg <= (wdata[15:0] > uart_pkg::BAUD_INC_MAX) ? uart_pkg::BAUD_INC_MAX : wdata[15:0];
            end
            if (addr == uart_pkg::OFF_IMR) begin
                imr_reg <= wdata[uart_pkg::INT_W-1:0];
            end
        end
    end

    uart_fifo #(.W(8)) u_txf (
        .clk(clk), .rst_n(rst_n), .one_deep(!ctrl_reg.fifo_en), .push(tx_push), .pop(tx_pop),
        .wdata(wdata[7:0]), .rdata(tx_head), .count(tx_cnt), .full(tx_full)
    );

    uart_fifo #(.W(11)) u_rxf (
        .clk(clk), .rst_n(rst_n), .one_deep(!ctrl_reg.fifo_en), .push(rx_push), .pop(rx_pop),
        .wdata(rx_in), .rdata(rx_head), .count(rx_cnt), .full(rx_full)
    );

    assign tx_par = (ctrl_reg.parity == uart_pkg::PAR_STICK) ? ctrl_reg.stick :
                    (^(tsh_reg & dmask)) ^ (ctrl_reg.parity == uart_pkg::PAR_ODD);
    assign tx_pop = ts_reg[0] && ctrl_reg.tx_en && (tx_cnt != 5'h00) && (!ctrl_reg.flow || !cts_n);
    assign tx_done = ts_reg[4] && tick_reg && (ttick_reg == 4'hF) && !(ctrl_reg.stop2 && tbit_reg == 3'h0);

    // transmitter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ts_reg <= uart_pkg::S_IDLE;
            ttick_reg <= 4'h0;
            tbit_reg <= 3'h0;
            tsh_reg <= 8'h00;
        end else begin
            unique case (ts_reg)
                uart_pkg::S_IDLE: begin
                    ttick_reg <= 4'h0;
                    tbit_reg <= 3'h0;
                    if (tx_pop) begin
                        tsh_reg <= tx_head;
                        ts_reg <= uart_pkg::S_START;
                    end
                end
                uart_pkg::S_START: begin
                    if (tick_reg) begin
                        ttick_reg <= ttick_reg + 4'h1;
                        if (ttick_reg == 4'hF) begin
                            ts_reg <= uart_pkg::S_DATA;
                        end
                    end
                end
                uart_pkg::S_DATA: begin
                    if (tick_reg) begin
                        ttick_reg <= ttick_reg + 4'h1;
                        if (ttick_reg == 4'hF) begin
                            tbit_reg <= tbit_reg + 3'h1;
                            if (tbit_reg == nbits) begin
                                tbit_reg <= 3'h0;
                                ts_reg <= (ctrl_reg.parity == uart_pkg::PAR_NONE) ? uart_pkg::S_STOP
                                                                                  : uart_pkg::S_PAR;
                            end
                        end
                    end
                end
                uart_pkg::S_PAR: begin
                    if (tick_reg) begin
                        ttick_reg <= ttick_reg + 4'h1;
                        if (ttick_reg == 4'hF) begin
                            ts_reg <= uart_pkg::S_STOP;
                        end
                    end
                end
                uart_pkg::S_STOP: begin
                    if (tick_reg) begin
                        ttick_reg <= ttick_reg + 4'h1;
                        if (ttick_reg == 4'hF) begin
                            tbit_reg <= 3'h1;
                            if (tx_done) begin
                                ts_reg <= uart_pkg::S_IDLE;
                            end
                        end
                    end
                end
                default: ts_reg <= uart_pkg::S_IDLE;
            endcase
        end
    end

    always_comb begin
        unique case (ts_reg)
            uart_pkg::S_START: tx_next = 1'b0;
            uart_pkg::S_DATA: tx_next = tsh_reg[tbit_reg];
            uart_pkg::S_PAR: tx_next = tx_par;
            default: tx_next = 1'b1;
        endcase
        if (ctrl_reg.brk) begin
            tx_next = 1'b0;
        end
    end

    // receiver: two flop sync, third flop for edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_m_reg <= 1'b1;
            rx_s_reg <= 1'b1;
            rx_d_reg <= 1'b1;
        end else begin
            rx_m_reg <= rx;
            rx_s_reg <= rx_m_reg;
            rx_d_reg <= rx_s_reg;
        end
    end

    assign exp_par = (ctrl_reg.parity == uart_pkg::PAR_STICK) ? ctrl_reg.stick :
                     (^(rsh_reg & dmask)) ^ (ctrl_reg.parity == uart_pkg::PAR_ODD);
    assign rx_in.data = rsh_reg & dmask;
    assign rx_in.ferr = !rx_s_reg;
    assign rx_in.perr = (ctrl_reg.parity != uart_pkg::PAR_NONE) && (rpar_reg != exp_par);
    assign rx_in.brk = !rx_s_reg && (rsh_reg == 8'h00) &&
                       ((ctrl_reg.parity == uart_pkg::PAR_NONE) || !rpar_reg);
    assign rx_push = rs_reg[4] && tick_reg && (rtick_reg == 4'hF);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_reg <= uart_pkg::S_IDLE;
            rtick_reg <= 4'h0;
            rbit_reg <= 3'h0;
            rsh_reg <= 8'h00;
            rpar_reg <= 1'b0;
        end else begin
            unique case (rs_reg)
                uart_pkg::S_IDLE: begin
                    rtick_reg <= 4'h0;
                    rbit_reg <= 3'h0;
                    if (ctrl_reg.rx_en && rx_d_reg && !rx_s_reg) begin
                        rsh_reg <= 8'h00;
                        rs_reg <= uart_pkg::S_START;
                    end
                end
                uart_pkg::S_START: begin
                    if (tick_reg) begin
                        rtick_reg <= rtick_reg + 4'h1;
                        if (rtick_reg == 4'h7) begin
                            rtick_reg <= 4'h0;
                            rs_reg <= rx_s_reg ? uart_pkg::S_IDLE : uart_pkg::S_DATA;
                        end
                    end
                end
                uart_pkg::S_DATA: begin
                    if (tick_reg) begin
                        rtick_reg <= rtick_reg + 4'h1;
                        if (rtick_reg == 4'hF) begin
                            rsh_reg[rbit_reg] <= rx_s_reg;
                            rbit_reg <= rbit_reg + 3'h1;
                            if (rbit_reg == nbits) begin
                                rs_reg <= (ctrl_reg.parity == uart_pkg::PAR_NONE) ? uart_pkg::S_STOP
                                                                                  : uart_pkg::S_PAR;
                            end
                        end
                    end
                end
                uart_pkg::S_PAR: begin
                    if (tick_reg) begin
                        rtick_reg <= rtick_reg + 4'h1;
                        if (rtick_reg == 4'hF) begin
                            rpar_reg <= rx_s_reg;
                            rs_reg <= uart_pkg::S_STOP;
                        end
                    end
                end
                uart_pkg::S_STOP: begin
                    if (tick_reg) begin
                        rtick_reg <= rtick_reg + 4'h1;
                        if (rtick_reg == 4'hF) begin
                            rpar_reg <= 1'b0;
                            rs_reg <= uart_pkg::S_IDLE;
                        end
                    end
                end
                default: rs_reg <= uart_pkg::S_IDLE;
            endcase
        end
    end

    assign rx_lvl = (rx_cnt >= thr);
    assign tx_lvl = (tx_cnt <= thr);

    always_comb begin
        ev = '0;
        ev[uart_pkg::INT_RXLVL] = rx_lvl && !rx_lvl_reg;
        ev[uart_pkg::INT_TXLVL] = tx_lvl && !tx_lvl_reg;
        ev[uart_pkg::INT_TXDONE] = tx_done && (tx_cnt == 5'h00);
        ev[uart_pkg::INT_OVR] = rx_push && rx_full;
        ev[uart_pkg::INT_PERR] = rx_push && rx_in.perr;
        ev[uart_pkg::INT_FERR] = rx_push && rx_in.ferr && !rx_in.brk;
        ev[uart_pkg::INT_BRK] = rx_push && rx_in.brk;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            isr_reg <= '0;
            rx_lvl_reg <= 1'b0;
            tx_lvl_reg <= 1'b1;
            irq <= 1'b0;
        end else begin
            rx_lvl_reg <= rx_lvl;
            tx_lvl_reg <= tx_lvl;
            if (wr && addr == uart_pkg::OFF_ISR) begin
                isr_reg <= (isr_reg & ~wdata[uart_pkg::INT_W-1:0]) | ev;
            end else begin
                isr_reg <= isr_reg | ev;
            end
            irq <= |(isr_reg & imr_reg);
        end
    end

    // line outputs and dma requests
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx <= 1'b1;
            rts_n <= 1'b1;
            tx_dma_single <= 1'b0;
            tx_dma_burst <= 1'b0;
            rx_dma_single <= 1'b0;
            rx_dma_burst <= 1'b0;
        end else begin
            tx <= tx_next;
            rts_n <= ctrl_reg.flow && rx_full;
            tx_dma_single <= ctrl_reg.dma_tx_en && !tx_full && !tx_push;
            tx_dma_burst <= ctrl_reg.dma_tx_en && tx_lvl && !tx_push;
            rx_dma_single <= ctrl_reg.dma_rx_en && (rx_cnt != 5'h00) && !rx_pop;
            rx_dma_burst <= ctrl_reg.dma_rx_en && rx_lvl && !rx_pop;
        end
    end
endmodule

module dual_uart (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] rx,
    input wire logic [1:0] cts_n,
    output logic [1:0] tx,
    output logic [1:0] rts_n,
    output logic [1:0] irq,
    output logic [1:0] tx_dma_single,
    output logic [1:0] tx_dma_burst,
    output logic [1:0] rx_dma_single,
    output logic [1:0] rx_dma_burst
);
    logic [31:0] prd [2];
    logic [1:0] phit;
    logic done;
    logic sel;

    assign sel = paddr[uart_pkg::PORT_SEL_BIT];
    assign done = psel && penable && pready;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_port
            uart_port u_port (
                .clk(pclk), .rst_n(presetn),
                .wr(done && pwrite && (sel == 1'(i)) && (paddr[7:6] == 2'h0)),
                .rd(done && !pwrite && (sel == 1'(i)) && (paddr[7:6] == 2'h0)),
                .addr(paddr[4:0]), .wdata(pwdata), .rdata(prd[i]), .hit(phit[i]),
                .rx(rx[i]), .cts_n(cts_n[i]), .tx(tx[i]), .rts_n(rts_n[i]), .irq(irq[i]),
                .tx_dma_single(tx_dma_single[i]), .tx_dma_burst(tx_dma_burst[i]),
                .rx_dma_single(rx_dma_single[i]), .rx_dma_burst(rx_dma_burst[i])
            );
        end
    endgenerate

    // apb: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                prdata <= (phit[sel] && paddr[7:6] == 2'h0 && !pwrite) ? prd[sel] : 32'h0000_0000;
                pslverr <= !(phit[sel] && paddr[7:6] == 2'h0);
            end else begin
                pslverr <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** verification/dual_uart_assertions.sv ***
// concurrent checks on the top ports
`timescale 1ns/100ps
`default_nettype none
module dual_uart_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] tx
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        s_setup ##1 (psel && penable);
    endsequence
    a_access_answer: assert property (s_access |=> pready)
        else $error("no answer in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_cause: assert property (pready |-> psel && penable)
        else $error("ready without access");
    a_bad_addr: assert property (pready && paddr[7:6] != 2'h0 |-> pslverr)
        else $error("bad address not refused");
    a_offset_ok: assert property (pready && paddr[7:6] == 2'h0 && paddr[4:0] < 5'h18 && paddr[1:0] == 2'h0
        |-> !pslverr)
        else $error("mapped offset refused");
    a_error_pair: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_zero_data: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
        else $error("read data not zero");
    a_bit_hold: assert property ($fell(tx[0]) |=> !tx[0] [*8])
        else $error("serial bit too short");
endmodule
`default_nettype wire

// *** verification/serial_partner.sv ***
// remote serial device that echoes each character
`timescale 1ns/100ps
`default_nettype none
module serial_partner #(parameter real BIT_NS = 333.34) (
    input wire logic line_in,
    input wire logic [3:0] nbits,
    input wire logic rts_n,
    output logic line_out,
    output logic [7:0] got,
    output int got_cnt
);
    logic [7:0] b;
    int w;
    initial begin
        line_out = 1'h1;
        got = 8'h0;
        got_cnt = 0;
        forever begin
            @(negedge line_in);
            w = nbits;
            b = 8'h0;
            #(BIT_NS / 2);
            for (int i = 0; i < w; i++) begin
                #(BIT_NS);
                b[i] = line_in;
            end
            #(BIT_NS);
            got = b;
            got_cnt++;
            wait (rts_n == 1'h0);
            line_out = 1'h0;
            #(BIT_NS);
            for (int i = 0; i < w; i++) begin
                line_out = b[i];
                #(BIT_NS);
            end
            line_out = 1'h1;
            #(BIT_NS);
        end
    end
endmodule
`default_nettype wire

// *** verification/test_async_serial_port_with_fifos.sv ***
// testbench for the dual serial port
`timescale 1ns/100ps
`default_nettype none
module test_async_serial_port_with_fifos;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line;
    logic [7:0] paddr, got;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] rx, cts_n, tx, rts_n, irq, tds, tdb, rds, rdb;
    logic [3:0] nbits;
    int got_cnt, failures, checks_done, n;
    row_t rows [11];
    assign rx = {tx[1], line};
    dual_uart dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx),
        .cts_n(cts_n), .tx(tx), .rts_n(rts_n), .irq(irq), .tx_dma_single(tds), .tx_dma_burst(tdb),
        .rx_dma_single(rds), .rx_dma_burst(rdb));
    serial_partner peer_u (.line_in(tx[0]), .nbits(nbits), .rts_n(rts_n[0]), .line_out(line), .got(got),
        .got_cnt(got_cnt));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        r = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task wait_peer(input int c);
        for (int k = 0; k < 3000 && got_cnt < c; k++) @(posedge pclk);
    endtask
    task wait_rx();
        r = 32'hFFFFFFFF;
        for (int k = 0; k < 300 && r[2] !== 1'h0; k++) apb(1'h0, 8'h04, 32'h0);
    endtask
    task summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        #400_000;
        failures++;
        summarize();
    end
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cts_n = 2'h0;
        nbits = 4'h8;
        rows = '{'{1'h0, 8'h0C, 32'h020F}, '{1'h0, 8'h08, 32'h0970}, '{1'h0, 8'h14, 32'h0},
            '{1'h0, 8'h04, 32'h25}, '{1'h0, 8'h18, 32'h0}, '{1'h0, 8'h48, 32'h0}, '{1'h1, 8'h08, 32'hFFFF},
            '{1'h0, 8'h08, 32'hF5C2}, '{1'h1, 8'h2C, 32'h0}, '{1'h0, 8'h2C, 32'h0}, '{1'h0, 8'h0C, 32'h020F}};
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk({28'h0, tx, irq}, 32'hC);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk(r, rows[i].d);
        end
        apb(1'h1, 8'h00, 32'h5A);
        wait_peer(1);
        chk({24'h0, got}, 32'h5A);
        wait_rx();
        apb(1'h0, 8'h00, 32'h0);
        chk(r, 32'h5A);
        apb(1'h0, 8'h10, 32'h0);
        chk(r & 32'h4, 32'h4);
        apb(1'h1, 8'h14, 32'h4);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq[0]}, 32'h1);
        apb(1'h1, 8'h10, 32'h7F);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq[0]}, 32'h0);
        apb(1'h1, 8'h0C, 32'h0203);
        nbits = 4'h5;
        apb(1'h1, 8'h00, 32'hEF);
        wait_peer(2);
        chk({24'h0, got}, 32'h0F);
        wait_rx();
        apb(1'h1, 8'h0C, 32'h060F);
        nbits = 4'h8;
        cts_n <= 2'h1;
        apb(1'h1, 8'h00, 32'h3C);
        repeat (300) @(posedge pclk);
        chk(32'(got_cnt), 32'h2);
        cts_n <= 2'h0;
        wait_peer(3);
        chk({24'h0, got}, 32'h3C);
        apb(1'h1, 8'h0C, 32'hC20F);
        for (n = 0; n < 2000 && rdb[0] !== 1'h1; n++) @(posedge pclk);
        chk({24'h0, tds, tdb, rds, rdb}, 32'h55);
        apb(1'h0, 8'h00, 32'h0);
        chk(r, 32'h0F);
        repeat (2) @(posedge pclk);
        chk({30'h0, rds[0], rdb[0]}, 32'h2);
        apb(1'h1, 8'h28, 32'hF5C2);
        apb(1'h1, 8'h2C, 32'h0403);
        apb(1'h1, 8'h20, 32'h13);
        for (n = 0; n < 400 && rts_n[1] !== 1'h1; n++) @(posedge pclk);
        chk({31'h0, rts_n[1]}, 32'h1);
        apb(1'h0, 8'h20, 32'h0);
        chk(r, 32'h13);
        @(posedge pclk);
        chk({31'h0, rts_n[1]}, 32'h0);
        summarize();
    end
endmodule
bind dual_uart dual_uart_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx(tx));
`default_nettype wire
